// ### lmon_pkg.sv
// Constants and carrier types for the line test pattern and alarm monitor
package lmon_pkg;

	// Signal loss declare counts, in pulse intervals
	localparam int LOS_N_T1_0 = 175;
	localparam int LOS_N_T1_1 = 1544;
	localparam int LOS_N_E1_0 = 32;
	localparam int LOS_N_E1_1 = 2048;
	// Signal loss clear window and zero-run limits
	localparam int LOS_M_T1 = 128;
	localparam int LOS_M_E1 = 32;
	localparam int LOS_ZRUN_T1 = 100;
	localparam int LOS_ZRUN_E1 = 16;
	// 12.5 percent mark density is one eighth of the window
	localparam int LOS_DENS_SHIFT = 3;
	localparam int LOS_CNT_W = 12;

	// Threshold code decode, magnitude of Q below nominal in dB
	localparam logic [4:0] THR_MAX_CODE = 5'h0a;
	localparam logic [5:0] THR_BASE_DB = 6'h04;
	localparam logic [5:0] THR_STEP_DB = 6'h02;

	// Alarm indication blocks and zero minimums
	localparam int AIS_BLK_E1 = 512;
	localparam int AIS_BLK_T1 = 8192;
	localparam logic [3:0] AIS_ZMIN_E1 = 4'h3;
	localparam logic [3:0] AIS_ZMIN_T1 = 4'h9;
	localparam int AIS_CNT_W = 14;

	// Test source select codes
	localparam logic [1:0] PAT_NORMAL = 2'h0;
	localparam logic [1:0] PAT_ONES = 2'h1;
	localparam logic [1:0] PAT_PRBS = 2'h2;

	// Generator polynomials and zero suppression
	localparam int QRSS_LEN = 20;
	localparam int QRSS_TAP = 17;
	localparam int PRBS_LEN = 15;
	localparam int PRBS_TAP = 14;
	localparam logic [3:0] QRSS_ZLIM = 4'he;
	localparam logic [19:0] LFSR_SEED = 20'hfffff;

	// Receive sync hopping window
	localparam logic [5:0] SYNC_WIN_LAST = 6'h3f;
	localparam logic [6:0] SYNC_MAX_ERR = 7'h06;

	// Error counter
	localparam logic [1:0] ERR_SEL_PATTERN = 2'h0;
	localparam int ERRCNT_W = 16;

	typedef struct packed {
		logic carrier_standard_select;
		logic loss_criteria_select;
		logic equalizer_enable;
		logic [4:0] signal_loss_threshold_code;
		logic cdr_enable;
		logic hw_control_mode;
		logic [1:0] tx_test_source_select;
		logic [1:0] tx_test_source_pins;
		logic test_source_clock_select;
		logic pseudo_random_invert;
		logic pseudo_random_sync_edge_select;
		logic pseudo_random_sync_irq_mask;
		logic [1:0] error_source_select;
	} lmon_cfg_t;

	typedef struct packed {
		logic valid;
		logic data;
		logic below_q;
		logic above_p;
	} lmon_rx_t;

	typedef enum logic [1:0] {
		LOS_OK = 2'b01,
		LOS_LOST = 2'b10
	} lmon_los_state_t;

endpackage

// ### lmon_monitor.sv
// Per-channel signal loss, alarm, test pattern and pattern checker logic
//
// Overview of operation
// R01: T1 loss: 175/1544 below, 128 above clears
// R02: E1 select 0: 32 below declares, 32 clear
// R03: E1 select 1: 2048 below declares
// R04: Threshold code: -4 dB down 2 dB steps
// R05: Criteria chosen by standard and criteria bits
// R06: Alarm detect only with recovery enabled
// R07: E1 criteria bit picks alarm criterion
// R08: E1: two 512-bit blocks under 3 zeros
// R09: T1: 8192-bit block under 9 zeros
// R10: Pattern clock: transmit clock or master clock
// R11: Select 00, clock select 0: data passes
// R12: Hardware mode takes select from pins
// R13: Select 01 sends all ones
// R14: Clock select 1, select 00 sends zeros
// R15: 2^20-1 T1, 2^15-1 E1 sequences
// R16: Select 10 sends sequence, MSB first
// R17: Invert bit inverts generated sequence
// R18: Sync: at most 6 errors per 64 bits
// R19: Sync changes latched, edge select chooses
// R20: Interrupt when flag and mask both set
// R21: Error source 00 counts pattern errors
`timescale 1ns/1ps
`default_nettype none

module lmon_monitor #(
	parameter int AIS_T1_BLOCK = lmon_pkg::AIS_BLK_T1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire lmon_pkg::lmon_cfg_t cfg,
	input wire lmon_pkg::lmon_rx_t rx,
	input wire logic tx_data,
	input wire logic transmit_line_clock,
	input wire logic master_clock_tick,
	input wire logic sync_irq_clear,
	input wire logic err_count_clear,
	output logic signal_loss_q,
	output logic [5:0] threshold_db_q,
	output logic threshold_reserved_q,
	output logic alarm_indication_status_q,
	output logic tx_out_q,
	output logic tx_out_valid_q,
	output logic pseudo_random_sync_status_q,
	output logic pseudo_random_sync_irq_flag_q,
	output logic irq_q,
	output logic [15:0] err_count_q
);

	generate
		if (AIS_T1_BLOCK < 16 || AIS_T1_BLOCK >= (1 << lmon_pkg::AIS_CNT_W)) begin
			$error("AIS_T1_BLOCK out of range");
		end
	endgenerate

	function automatic logic thr_reserved(input logic [4:0] code);
		thr_reserved = code > lmon_pkg::THR_MAX_CODE;
	endfunction

	function automatic logic [5:0] thr_db(input logic [4:0] code);
		thr_db = lmon_pkg::THR_BASE_DB + lmon_pkg::THR_STEP_DB * {1'b0, code};
	endfunction

	logic t1;
	assign t1 = cfg.carrier_standard_select;

	// Threshold decode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			threshold_db_q <= 6'h00;
			threshold_reserved_q <= 1'b0;
		end else if (ce) begin
			if (cfg.equalizer_enable && !thr_reserved(cfg.signal_loss_threshold_code)) begin
				threshold_db_q <= thr_db(cfg.signal_loss_threshold_code); // [R04]
			end else begin
				threshold_db_q <= 6'h00;
			end
			threshold_reserved_q <= cfg.equalizer_enable && thr_reserved(cfg.signal_loss_threshold_code); // [R04]
		end
	end

	// Signal loss criteria selection
	logic [11:0] los_n;
	logic [11:0] los_m;
	logic [11:0] los_zlim;
	always_comb begin
		if (t1) begin
			los_n = cfg.loss_criteria_select ? 12'(lmon_pkg::LOS_N_T1_1) : 12'(lmon_pkg::LOS_N_T1_0); // [R05] [R01]
			los_m = 12'(lmon_pkg::LOS_M_T1); // [R01]
			los_zlim = 12'(lmon_pkg::LOS_ZRUN_T1); // [R01]
		end else begin
			los_n = cfg.loss_criteria_select ? 12'(lmon_pkg::LOS_N_E1_1) : 12'(lmon_pkg::LOS_N_E1_0); // [R05] [R02] [R03]
			los_m = 12'(lmon_pkg::LOS_M_E1); // [R02] [R03]
			los_zlim = 12'(lmon_pkg::LOS_ZRUN_E1); // [R02] [R03]
		end
	end

	lmon_pkg::lmon_los_state_t los_q;
	logic [11:0] los_cnt_q;
	logic [11:0] clr_ones_q;
	logic [11:0] clr_zrun_q;
	logic clr_active_q;
	logic [11:0] ones_next;
	logic [11:0] zrun_next;
	assign ones_next = clr_ones_q + {11'h000, rx.data};
	assign zrun_next = rx.data ? 12'h000 : clr_zrun_q + 12'h001;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			los_q <= lmon_pkg::LOS_OK;
			los_cnt_q <= 12'h000;
			clr_ones_q <= 12'h000;
			clr_zrun_q <= 12'h000;
			clr_active_q <= 1'b0;
		end else if (ce && rx.valid) begin
			case (los_q)
				lmon_pkg::LOS_OK: begin
					clr_active_q <= 1'b0;
					if (!rx.below_q) begin
						los_cnt_q <= 12'h000;
					end else if (los_cnt_q == los_n - 12'h001) begin
						los_q <= lmon_pkg::LOS_LOST; // [R01] [R02] [R03]
						los_cnt_q <= 12'h000;
					end else begin
						los_cnt_q <= los_cnt_q + 12'h001;
					end
				end
				lmon_pkg::LOS_LOST: begin
					if (!clr_active_q) begin
						if (rx.above_p && rx.data) begin
							clr_active_q <= 1'b1;
							los_cnt_q <= 12'h001;
							clr_ones_q <= 12'h001;
							clr_zrun_q <= 12'h000;
						end
					end else if (!rx.above_p || zrun_next >= los_zlim) begin
						clr_active_q <= 1'b0; // [R01] [R02]
					end else if (los_cnt_q == los_m - 12'h001) begin
						clr_active_q <= 1'b0;
						los_cnt_q <= 12'h000;
						if (ones_next >= (los_m >> lmon_pkg::LOS_DENS_SHIFT)) begin
							los_q <= lmon_pkg::LOS_OK; // [R01] [R02] [R03]
						end
					end else begin
						los_cnt_q <= los_cnt_q + 12'h001;
						clr_ones_q <= ones_next;
						clr_zrun_q <= zrun_next;
					end
				end
				default: begin
					los_q <= lmon_pkg::LOS_LOST;
					clr_active_q <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			signal_loss_q <= 1'b0;
		end else if (ce) begin
			signal_loss_q <= (los_q == lmon_pkg::LOS_LOST);
		end
	end

	// Alarm indication detection
	logic [13:0] ais_blk;
	logic [3:0] ais_zmin;
	logic [13:0] ais_bcnt_q;
	logic [3:0] ais_zcnt_q;
	logic ais_prev_low_q;
	logic [3:0] ais_znext;
	logic ais_low;
	assign ais_blk = t1 ? 14'(AIS_T1_BLOCK) : 14'(lmon_pkg::AIS_BLK_E1); // [R08] [R09]
	assign ais_zmin = t1 ? lmon_pkg::AIS_ZMIN_T1 : lmon_pkg::AIS_ZMIN_E1;
	assign ais_znext = (!rx.data && ais_zcnt_q < ais_zmin) ? ais_zcnt_q + 4'h1 : ais_zcnt_q;
	assign ais_low = ais_znext < ais_zmin;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ais_bcnt_q <= 14'h0000;
			ais_zcnt_q <= 4'h0;
			ais_prev_low_q <= 1'b0;
			alarm_indication_status_q <= 1'b0;
		end else if (ce) begin
			if (!cfg.cdr_enable) begin
				ais_bcnt_q <= 14'h0000; // [R06]
				ais_zcnt_q <= 4'h0;
				ais_prev_low_q <= 1'b0;
			end else if (rx.valid) begin
				if (ais_bcnt_q >= ais_blk - 14'h0001) begin
					ais_bcnt_q <= 14'h0000;
					ais_zcnt_q <= 4'h0;
					ais_prev_low_q <= ais_low;
					if (t1 || cfg.loss_criteria_select) begin
						alarm_indication_status_q <= ais_low; // [R09] [R07] [R06]
					end else if (ais_low == ais_prev_low_q) begin
						alarm_indication_status_q <= ais_low; // [R08] [R07] [R06]
					end
				end else begin
					ais_bcnt_q <= ais_bcnt_q + 14'h0001;
					ais_zcnt_q <= ais_znext;
				end
			end
		end
	end

	// Transmit test pattern insertion
	logic pat_tick;
	logic [1:0] pat_sel;
	logic [19:0] lfsr_q;
	logic [3:0] gen_zrun_q;
	logic lfsr_fb;
	logic prbs_bit;
	assign pat_tick = cfg.test_source_clock_select ? master_clock_tick : transmit_line_clock; // [R10]
	assign pat_sel = cfg.hw_control_mode ? cfg.tx_test_source_pins : cfg.tx_test_source_select; // [R12]
	assign lfsr_fb = t1 ? lfsr_q[lmon_pkg::QRSS_LEN-1] ^ lfsr_q[lmon_pkg::QRSS_TAP-1]
		: lfsr_q[lmon_pkg::PRBS_LEN-1] ^ lfsr_q[lmon_pkg::PRBS_TAP-1]; // [R15]
	assign prbs_bit = t1 ? (lfsr_q[lmon_pkg::QRSS_LEN-1] || gen_zrun_q >= lmon_pkg::QRSS_ZLIM)
		: lfsr_q[lmon_pkg::PRBS_LEN-1]; // [R15] [R16]

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lfsr_q <= lmon_pkg::LFSR_SEED;
			gen_zrun_q <= 4'h0;
		end else if (ce && pat_tick) begin
			lfsr_q <= {lfsr_q[18:0], lfsr_fb};
			gen_zrun_q <= prbs_bit ? 4'h0 : gen_zrun_q + 4'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_out_q <= 1'b0;
			tx_out_valid_q <= 1'b0;
		end else if (ce) begin
			tx_out_valid_q <= pat_tick; // [R10]
			if (pat_tick) begin
				case (pat_sel)
					lmon_pkg::PAT_NORMAL: tx_out_q <= cfg.test_source_clock_select ? 1'b0 : tx_data; // [R11] [R14]
					lmon_pkg::PAT_ONES: tx_out_q <= 1'b1; // [R13]
					lmon_pkg::PAT_PRBS: tx_out_q <= prbs_bit ^ cfg.pseudo_random_invert; // [R16] [R17]
					default: tx_out_q <= tx_data;
				endcase
			end
		end
	end

	// Receive pattern checker
	logic [19:0] chk_q;
	logic rx_bit;
	logic chk_err;
	logic [5:0] win_cnt_q;
	logic [6:0] win_err_q;
	logic [6:0] win_err_next;
	assign rx_bit = rx.data ^ cfg.pseudo_random_invert;
	assign chk_err = rx_bit ^ (t1 ? chk_q[lmon_pkg::QRSS_LEN-1] ^ chk_q[lmon_pkg::QRSS_TAP-1]
		: chk_q[lmon_pkg::PRBS_LEN-1] ^ chk_q[lmon_pkg::PRBS_TAP-1]); // [R15]
	assign win_err_next = win_err_q + {6'h00, chk_err};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chk_q <= 20'h00000;
			win_cnt_q <= 6'h00;
			win_err_q <= 7'h00;
			pseudo_random_sync_status_q <= 1'b0;
		end else if (ce && rx.valid) begin
			chk_q <= {chk_q[18:0], rx_bit};
			win_cnt_q <= win_cnt_q + 6'h01;
			if (win_cnt_q == lmon_pkg::SYNC_WIN_LAST) begin
				win_err_q <= 7'h00;
				pseudo_random_sync_status_q <= win_err_next <= lmon_pkg::SYNC_MAX_ERR; // [R18]
			end else begin
				win_err_q <= win_err_next;
			end
		end
	end

	// Sync change capture and interrupt
	logic sync_prev_q;
	logic sync_set;
	assign sync_set = cfg.pseudo_random_sync_edge_select
		? (pseudo_random_sync_status_q ^ sync_prev_q)
		: (pseudo_random_sync_status_q & ~sync_prev_q); // [R19]

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_prev_q <= 1'b0;
			pseudo_random_sync_irq_flag_q <= 1'b0;
			irq_q <= 1'b0;
		end else if (ce) begin
			sync_prev_q <= pseudo_random_sync_status_q;
			pseudo_random_sync_irq_flag_q <= sync_set
				| (pseudo_random_sync_irq_flag_q & ~sync_irq_clear); // [R19]
			irq_q <= pseudo_random_sync_irq_flag_q & cfg.pseudo_random_sync_irq_mask; // [R20]
		end
	end

	// Pattern error counter
	logic err_inc;
	assign err_inc = rx.valid && chk_err && cfg.error_source_select == lmon_pkg::ERR_SEL_PATTERN; // [R21]

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			err_count_q <= 16'h0000;
		end else if (ce) begin
			if (err_count_clear) begin
				err_count_q <= {15'h0000, err_inc};
			end else if (err_inc && err_count_q != 16'hffff) begin
				err_count_q <= err_count_q + 16'h0001; // [R21]
			end
		end
	end

endmodule

`default_nettype wire

// ### lmon_line_model.sv
// Line side and framer model: bit strobes, ticks and receive levels
`timescale 1ns/1ps
`default_nettype none

module lmon_line_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] mode,
	input wire logic lb_data,
	output lmon_pkg::lmon_rx_t rx,
	output logic tick,
	output logic mtick
);
	logic [1:0] cnt_q;

	// Modes: 0 silent line, 1 all marks, 2 transmit looped back
	always @(negedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 2'h0;
		end else begin
			cnt_q <= cnt_q + 2'h1;
		end
	end
	assign tick = cnt_q[0];
	assign mtick = (cnt_q == 2'h3);
	assign rx.valid = cnt_q[0];
	assign rx.data = (mode == 2'h2) ? lb_data : (mode == 2'h1);
	assign rx.below_q = (mode == 2'h0);
	assign rx.above_p = (mode != 2'h0);
endmodule

`default_nettype wire

// ### lmon_assertions.sv
// Checker of the monitor ports
`timescale 1ns/1ps
`default_nettype none

module lmon_assertions #(
	parameter int AIS_T1_BLOCK = 8192
) (
	input wire logic clk,
	input wire logic rst,
	input wire lmon_pkg::lmon_cfg_t cfg,
	input wire logic tx_data,
	input wire logic transmit_line_clock,
	input wire logic master_clock_tick,
	input wire logic ce,
	input wire logic err_count_clear,
	input wire logic [5:0] threshold_db_q,
	input wire logic alarm_indication_status_q,
	input wire logic tx_out_q,
	input wire logic tx_out_valid_q,
	input wire logic pseudo_random_sync_status_q,
	input wire logic pseudo_random_sync_irq_flag_q,
	input wire logic irq_q,
	input wire logic [15:0] err_count_q
);
	wire logic [1:0] src;
	wire logic sel_tick;
	assign src = cfg.hw_control_mode ? cfg.tx_test_source_pins :
		cfg.tx_test_source_select;
	assign sel_tick = cfg.test_source_clock_select ? master_clock_tick :
		transmit_line_clock;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	property p_tick;
		tx_out_valid_q && $past(ce) |-> $past(sel_tick);
	endproperty
	a_tick: assert property (p_tick) else $error("pulse without tick");
	property p_ones;
		tx_out_valid_q && $past(ce) &&
			$past(src) == lmon_pkg::PAT_ONES |-> tx_out_q;
	endproperty
	a_ones: assert property (p_ones) else $error("ones not sent");
	property p_norm;
		tx_out_valid_q && $past(ce) &&
			!$past(cfg.test_source_clock_select) &&
			$past(src) == lmon_pkg::PAT_NORMAL |-> tx_out_q == $past(tx_data);
	endproperty
	a_norm: assert property (p_norm) else $error("data altered");
	property p_zero;
		tx_out_valid_q && $past(ce) && $past(cfg.test_source_clock_select) &&
			$past(src) == lmon_pkg::PAT_NORMAL |-> !tx_out_q;
	endproperty
	a_zero: assert property (p_zero) else $error("zeros not sent");
	property p_thr;
		ce && cfg.equalizer_enable &&
			cfg.signal_loss_threshold_code <= 5'h0a |=>
			threshold_db_q == 6'h04 + $past({cfg.signal_loss_threshold_code, 1'b0});
	endproperty
	a_thr: assert property (p_thr) else $error("threshold wrong");
	property p_hold;
		!cfg.cdr_enable |=> $stable(alarm_indication_status_q);
	endproperty
	a_hold: assert property (p_hold) else $error("alarm moved");
	property p_rise;
		$rose(pseudo_random_sync_status_q) && ce |=>
			pseudo_random_sync_irq_flag_q;
	endproperty
	a_rise: assert property (p_rise) else $error("rise not latched");
	property p_fall;
		$fell(pseudo_random_sync_status_q) &&
			cfg.pseudo_random_sync_edge_select && ce |=>
			pseudo_random_sync_irq_flag_q;
	endproperty
	a_fall: assert property (p_fall) else $error("fall not latched");
	property p_irq;
		$past(ce) |-> irq_q == $past(pseudo_random_sync_irq_flag_q &
			cfg.pseudo_random_sync_irq_mask);
	endproperty
	a_irq: assert property (p_irq) else $error("irq wrong");
	property p_err;
		!err_count_clear |=> err_count_q >= $past(err_count_q);
	endproperty
	a_err: assert property (p_err) else $error("count dropped");
	c_sync: cover property ($rose(pseudo_random_sync_status_q));
	c_ais: cover property ($rose(alarm_indication_status_q));
	c_irq: cover property ($rose(irq_q));
endmodule

bind lmon_monitor lmon_assertions #(.AIS_T1_BLOCK(AIS_T1_BLOCK)) u_chk (
	.clk(clk), .rst(rst), .cfg(cfg), .tx_data(tx_data),
	.transmit_line_clock(transmit_line_clock),
	.master_clock_tick(master_clock_tick), .ce(ce),
	.err_count_clear(err_count_clear), .threshold_db_q(threshold_db_q),
	.alarm_indication_status_q(alarm_indication_status_q),
	.tx_out_q(tx_out_q), .tx_out_valid_q(tx_out_valid_q),
	.pseudo_random_sync_status_q(pseudo_random_sync_status_q),
	.pseudo_random_sync_irq_flag_q(pseudo_random_sync_irq_flag_q),
	.irq_q(irq_q), .err_count_q(err_count_q));

`default_nettype wire

// ### tb_top.sv
// Self-checking bench of the monitor
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, tx_data = 1'b0;
	logic sic = 1'b0, ecc = 1'b0, tick, mtick, loss, rsv, ais, txo, txv;
	logic sync, flag, irq;
	logic [1:0] mode = 2'h1;
	logic [5:0] thr;
	logic [15:0] errc;
	lmon_pkg::lmon_rx_t rx;
	lmon_pkg::lmon_cfg_t cfg = '0;
	int num_errors = 0, cmp_count = 0, cyc = 0;

	always #10 clk = ~clk;

	lmon_line_model u_line (.clk(clk), .rst(rst), .mode(mode), .lb_data(txo),
		.rx(rx), .tick(tick), .mtick(mtick));
	lmon_monitor #(.AIS_T1_BLOCK(64)) DUT (.clk(clk), .rst(rst), .ce(ce),
		.cfg(cfg), .rx(rx), .tx_data(tx_data), .transmit_line_clock(tick),
		.master_clock_tick(mtick), .sync_irq_clear(sic), .err_count_clear(ecc),
		.signal_loss_q(loss), .threshold_db_q(thr), .threshold_reserved_q(rsv),
		.alarm_indication_status_q(ais), .tx_out_q(txo), .tx_out_valid_q(txv),
		.pseudo_random_sync_status_q(sync),
		.pseudo_random_sync_irq_flag_q(flag), .irq_q(irq), .err_count_q(errc));

	task check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task run(input int n);
		repeat (2 * n) @(negedge clk);
	endtask
	task conclude;
		$display("errors=%0d compares=%0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			conclude();
		end
	end

	initial begin
		cfg.equalizer_enable = 1'b1;
		cfg.signal_loss_threshold_code = 5'h05;
		cfg.cdr_enable = 1'b1;
		cfg.tx_test_source_select = 2'h1;
		cfg.pseudo_random_sync_irq_mask = 1'b1;
		repeat (16) @(negedge clk);
		rst <= 1'b0;
		check({loss, ais, irq}, 16'h0);
		run(4); check(txo, 1);
		check(thr, 16'h0e);
		cfg.signal_loss_threshold_code = 5'h0b;
		run(1); check(rsv, 1);
		cfg.hw_control_mode = 1'b1; cfg.tx_test_source_pins = 2'h1;
		cfg.tx_test_source_select = 2'h0;
		run(3); check(txo, 1);
		cfg.hw_control_mode = 1'b0;
		run(3); check(txo, 0);
		tx_data = 1'b1;
		run(3); check(txo, 1);
		cfg.test_source_clock_select = 1'b1;
		run(4); check(txo, 0);
		run(1100); check(ais, 1);
		cfg.cdr_enable = 1'b0; mode = 2'h0;
		run(600); check(ais, 1);
		check(loss, 1);
		cfg.cdr_enable = 1'b1;
		run(1100); check(ais, 0);
		mode = 2'h1;
		run(20); check(loss, 1);
		run(20); check(loss, 0);
		mode = 2'h0;
		run(28); check(loss, 0);
		run(10); check(loss, 1);
		cfg.loss_criteria_select = 1'b1; mode = 2'h1;
		run(40); mode = 2'h0;
		run(100); check(loss, 0);
		run(2000); check(loss, 1);
		cfg.carrier_standard_select = 1'b1; cfg.loss_criteria_select = 1'b0;
		mode = 2'h1;
		run(200); check({loss, ais}, 16'h1);
		mode = 2'h0;
		run(170); check({loss, ais}, 16'h0);
		run(10); check(loss, 1);
		cfg.carrier_standard_select = 1'b0; cfg.test_source_clock_select = 1'b0;
		cfg.tx_test_source_select = 2'h2; mode = 2'h1;
		run(200); check({sync, 14'h0, errc != 16'h0}, 16'h1);
		sic = 1'b1; @(negedge clk); sic = 1'b0; mode = 2'h2;
		run(300); check({sync, flag, irq}, 16'h7);
		cfg.pseudo_random_sync_irq_mask = 1'b0;
		run(1); check(irq, 0);
		ecc = 1'b1; @(negedge clk); ecc = 1'b0;
		run(200); check(errc, 0);
		sic = 1'b1; @(negedge clk); sic = 1'b0; mode = 2'h1;
		run(200); check({sync, flag}, 16'h0);
		cfg.pseudo_random_sync_edge_select = 1'b1; mode = 2'h2;
		run(300); sic = 1'b1; @(negedge clk); sic = 1'b0; mode = 2'h1;
		run(200); check({sync, flag}, 16'h1);
		ce = 1'b0; mode = 2'h0;
		run(100); check({loss, sync, flag}, 16'h1);
		ce = 1'b1;
		run(40); check(loss, 1);
		conclude();
	end
endmodule

`default_nettype wire
